// *** design/avr_routing_ctl.sv ***
// Routing and mode control for a fiber video extender pair: transmit input
// selection, receive conversion, local serial routing, register port.
// Assumes pixel streams, byte streams and register port share clk; the
// detect pins (activity, over-rate, deep colour) are asynchronous.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module avr_routing_ctl
  import avr_pkg::*;
#(
  parameter int VID_W = 24,
  parameter logic [REG_W-1:0] BAUD_DIV = REG_W'(BAUD_DIV_RST)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_W-1:0] reg_rdata,
  input wire logic [1:0] in_active_pin,
  input wire logic rate_high_pin,
  input wire logic deep_color_pin,
  input wire logic [1:0] in_valid,
  input wire logic [1:0] in_sof,
  input wire logic [1:0] in_eol,
  input wire logic [1:0] in_eof,
  input wire logic [VID_W-1:0] in0_data,
  input wire logic [VID_W-1:0] in1_data,
  output logic loc_valid,
  output logic loc_sof,
  output logic loc_eol,
  output logic loc_eof,
  output logic [VID_W-1:0] loc_data,
  output logic fib_valid,
  output logic fib_sof,
  output logic fib_eol,
  output logic fib_eof,
  output logic [VID_W-1:0] fib_data,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eol,
  input wire logic rx_eof,
  input wire logic [VID_W-1:0] rx_data,
  output logic raw_valid,
  output logic raw_sof,
  output logic raw_eol,
  output logic raw_eof,
  output logic [VID_W-1:0] raw_data,
  output logic first_converted_output_valid,
  output logic first_converted_output_sof,
  output logic first_converted_output_eol,
  output logic [VID_W-1:0] first_converted_output_data,
  output logic second_converted_output_valid,
  output logic second_converted_output_sof,
  output logic second_converted_output_eol,
  output logic [VID_W-1:0] second_converted_output_data,
  input wire logic ser_idle,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_byte,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_byte,
  output logic baud_tick,
  input wire logic fib_ser_in_valid,
  input wire logic [7:0] fib_ser_in_byte,
  output logic fib_ser_out_valid,
  output logic [7:0] fib_ser_out_byte,
  output logic cpu_in_valid,
  output logic cpu_in_from_usb,
  output logic [7:0] cpu_in_byte,
  input wire logic cpu_out_valid,
  input wire logic [7:0] cpu_out_byte,
  input wire logic usb_valid,
  input wire logic [7:0] usb_byte,
  output logic usb_ready,
  input wire logic tcp_in_valid,
  input wire logic [7:0] tcp_in_byte,
  output logic tcp_out_valid,
  output logic [7:0] tcp_out_byte,
  output logic [REG_W-1:0] tcp_port
);

  localparam int C_W = VID_W / 3;

  function automatic avr_conv_e to_conv(input logic [1:0] code);
    to_conv = (code == 2'h1) ? CONV_SPLIT : (code == 2'h2) ? CONV_DOWN : CONV_TRANS;
  endfunction

  function automatic avr_ser_e to_ser(input logic [1:0] code);
    to_ser = (code == 2'h1) ? SER_CTRL : (code == 2'h2) ? SER_BRIDGE : SER_PASS;
  endfunction

  // Quarter-chroma packing: even lines carry Cb on even and Cr on odd
  // pixels, odd lines carry luma only; avoids a line buffer.
  function automatic logic [VID_W-1:0] down_px(input logic [VID_W-1:0] px,
                                                input logic odd_line,
                                                input logic odd_col);
    logic [C_W-1:0] y;
    logic [C_W-1:0] cb;
    logic [C_W-1:0] cr;
    y = px[3*C_W-1:2*C_W];
    cb = (odd_line || odd_col) ? '0 : px[2*C_W-1:C_W];
    cr = (odd_line || !odd_col) ? '0 : px[C_W-1:0];
    down_px = {y, cb, cr};
  endfunction

  // Registers
  logic [REG_W-1:0] ctrl_ff, prio_ff, half_ff, baud_ff, tcp_ff, rdata_ff;
  logic [REG_W-1:0] rd_mux, stat_w;

  // Pin synchronisers: bit0-1 activity, bit2 over-rate, bit3 deep colour
  logic [3:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [1:0] act, act_d_ff, rise;
  logic rate_high, deep;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      flt_ff <= '0;
      act_d_ff <= '0;
    end else begin
      s1_ff <= {deep_color_pin, rate_high_pin, in_active_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
      act_d_ff <= act;
    end
  end

  assign act = flt_ff[1:0];
  assign rate_high = flt_ff[2];
  assign deep = flt_ff[3];
  assign rise = act & ~act_d_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
      prio_ff <= PRIO_RST;
      half_ff <= HALF_RST;
      baud_ff <= BAUD_DIV;
      tcp_ff <= TCP_PORT_RST;
      rdata_ff <= '0;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) ctrl_ff <= reg_wdata;
      if (reg_wr && reg_addr == REG_PRIO) prio_ff <= reg_wdata;
      if (reg_wr && reg_addr == REG_HALF) half_ff <= reg_wdata;
      if (reg_wr && reg_addr == REG_BAUD) baud_ff <= reg_wdata;
      if (reg_wr && reg_addr == REG_TCP) tcp_ff <= reg_wdata;
      rdata_ff <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign tcp_port = tcp_ff;

  // Transmit selection
  avr_sel_e sel_mode;
  logic man_sel, sel_ff, last_ff, busy_ff, wait_ff, want, cur_sof;
  logic sel_valid, sel_sof, sel_eol, sel_eof, can_switch;
  logic [VID_W-1:0] sel_data;
  logic [PRIO_W-1:0] prio0, prio1;
  logic loc_v_ff, loc_s_ff, loc_l_ff, loc_e_ff;
  logic [VID_W-1:0] loc_d_ff;

  assign sel_mode = avr_sel_e'(ctrl_ff[CTRL_SELM_LSB +: 2]);
  assign man_sel = ctrl_ff[CTRL_MAN_BIT];
  assign prio0 = prio_ff[PRIO_W-1:0];
  assign prio1 = prio_ff[PRIO1_LSB +: PRIO_W];

  always_comb begin
    case (sel_mode)
      SEL_MANUAL: want = man_sel;
      SEL_FIRST: want = act[sel_ff] ? sel_ff : (act[!sel_ff] ? !sel_ff : sel_ff);
      SEL_PRIO: begin
        if (&act) want = (prio1 < prio0);
        else if (act[0]) want = 1'b0;
        else if (act[1]) want = 1'b1;
        else want = sel_ff;
      end
      SEL_LAST: want = (act == 2'h0) ? sel_ff : (act[last_ff] ? last_ff : act[1]);
      default: want = sel_ff;
    endcase
  end

  // One mux index: only one input can ever reach the outputs
  assign sel_valid = in_valid[sel_ff];
  assign sel_sof = in_sof[sel_ff];
  assign sel_eol = in_eol[sel_ff];
  assign sel_eof = in_eof[sel_ff];
  assign sel_data = sel_ff ? in1_data : in0_data;
  assign cur_sof = sel_valid && sel_sof;
  assign can_switch = !busy_ff && !cur_sof;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_ff <= 1'b0;
      last_ff <= 1'b0;
      busy_ff <= 1'b0;
      wait_ff <= 1'b1;
    end else begin
      if (rise[1] && !rise[0]) last_ff <= 1'b1;
      else if (rise[0]) last_ff <= 1'b0;
      if (can_switch && want != sel_ff) begin
        sel_ff <= want;
        wait_ff <= 1'b1;
      end else if (cur_sof) begin
        wait_ff <= 1'b0;
      end
      if (!act[sel_ff]) busy_ff <= 1'b0;
      else if (cur_sof) busy_ff <= 1'b1;
      else if (sel_valid && sel_eof) busy_ff <= 1'b0;
    end
  end

  // A freshly chosen input is held off until its next frame start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loc_v_ff <= 1'b0;
      loc_s_ff <= 1'b0;
      loc_l_ff <= 1'b0;
      loc_e_ff <= 1'b0;
      loc_d_ff <= '0;
    end else begin
      loc_v_ff <= sel_valid && (sel_sof || !wait_ff);
      loc_s_ff <= sel_sof;
      loc_l_ff <= sel_eol;
      loc_e_ff <= sel_eof;
      loc_d_ff <= sel_data;
    end
  end

  // Same flops feed both destinations, so the copies cannot differ
  assign loc_valid = loc_v_ff;
  assign loc_sof = loc_s_ff;
  assign loc_eol = loc_l_ff;
  assign loc_eof = loc_e_ff;
  assign loc_data = loc_d_ff;
  assign fib_valid = loc_v_ff;
  assign fib_sof = loc_s_ff;
  assign fib_eol = loc_l_ff;
  assign fib_eof = loc_e_ff;
  assign fib_data = loc_d_ff;

  // Receive side conversion
  avr_conv_e conv_ff, eff_conv, req_conv;
  logic [REG_W-1:0] col_ff, pix_col;
  logic odd_ff, first_ff, pix_odd, pix_first, left, frame_start;
  logic raw_v_ff, raw_s_ff, raw_l_ff, raw_e_ff;
  logic [VID_W-1:0] raw_d_ff, cv_px;
  logic a_v_ff, a_s_ff, a_l_ff, b_v_ff, b_s_ff, b_l_ff;
  logic [VID_W-1:0] a_d_ff, b_d_ff;
  logic a_v, a_s, a_l, b_v, b_s, b_l;

  assign frame_start = rx_valid && rx_sof;
  assign req_conv = deep ? CONV_TRANS : to_conv(ctrl_ff[CTRL_CONV_LSB +: 2]);
  assign eff_conv = frame_start ? req_conv : conv_ff;
  assign pix_col = rx_sof ? '0 : col_ff;
  assign pix_odd = rx_sof ? 1'b0 : odd_ff;
  assign pix_first = rx_sof ? 1'b1 : first_ff;
  assign left = pix_col < half_ff;
  assign cv_px = (eff_conv == CONV_DOWN) ? down_px(rx_data, pix_odd, pix_col[0]) :
                 rx_data;

  always_comb begin
    case (eff_conv)
      CONV_SPLIT: begin
        a_v = rx_valid && left;
        a_s = rx_sof;
        a_l = left && (rx_eol || pix_col == REG_W'(half_ff - 16'h0001));
        b_v = rx_valid && !left;
        b_s = pix_first && pix_col == half_ff;
        b_l = rx_eol;
      end
      default: begin
        a_v = rx_valid;
        a_s = rx_sof;
        a_l = rx_eol;
        b_v = rx_valid;
        b_s = rx_sof;
        b_l = rx_eol;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_ff <= CONV_TRANS;
      col_ff <= '0;
      odd_ff <= 1'b0;
      first_ff <= 1'b1;
    end else if (rx_valid) begin
      conv_ff <= eff_conv;
      col_ff <= rx_eol ? '0 : REG_W'(pix_col + 16'h0001);
      odd_ff <= rx_eol ? !pix_odd : pix_odd;
      first_ff <= rx_eol ? 1'b0 : pix_first;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raw_v_ff <= 1'b0;
      raw_s_ff <= 1'b0;
      raw_l_ff <= 1'b0;
      raw_e_ff <= 1'b0;
      raw_d_ff <= '0;
      a_v_ff <= 1'b0;
      a_s_ff <= 1'b0;
      a_l_ff <= 1'b0;
      a_d_ff <= '0;
      b_v_ff <= 1'b0;
      b_s_ff <= 1'b0;
      b_l_ff <= 1'b0;
      b_d_ff <= '0;
    end else begin
      raw_v_ff <= rx_valid;
      raw_s_ff <= rx_sof;
      raw_l_ff <= rx_eol;
      raw_e_ff <= rx_eof;
      raw_d_ff <= rx_data;
      a_v_ff <= a_v;
      a_s_ff <= a_s;
      a_l_ff <= a_l;
      a_d_ff <= cv_px;
      // Over-rate blanking is a best effort: the flag is pin-sampled, not measured
      b_v_ff <= b_v && !rate_high;
      b_s_ff <= b_s;
      b_l_ff <= b_l;
      b_d_ff <= cv_px;
    end
  end

  assign raw_valid = raw_v_ff;
  assign raw_sof = raw_s_ff;
  assign raw_eol = raw_l_ff;
  assign raw_eof = raw_e_ff;
  assign raw_data = raw_d_ff;
  assign first_converted_output_valid = a_v_ff;
  assign first_converted_output_sof = a_s_ff;
  assign first_converted_output_eol = a_l_ff;
  assign first_converted_output_data = a_d_ff;
  assign second_converted_output_valid = b_v_ff;
  assign second_converted_output_sof = b_s_ff;
  assign second_converted_output_eol = b_l_ff;
  assign second_converted_output_data = b_d_ff;

  // Serial routing
  avr_ser_e ser_ff;
  logic [REG_W-1:0] baud_cnt_ff;
  logic tick_ff, stx_v_ff, fso_v_ff, cpu_v_ff, cpu_u_ff, tco_v_ff;
  logic [7:0] stx_b_ff, fso_b_ff, cpu_b_ff, tco_b_ff;
  logic ctl_hit, tx_src_v;
  logic [7:0] tx_src_b;

  assign ctl_hit = (ser_ff == SER_CTRL) && ser_rx_valid;
  assign usb_ready = !ctl_hit;
  assign tx_src_v = (ser_ff == SER_PASS) ? fib_ser_in_valid :
                    (ser_ff == SER_CTRL) ? cpu_out_valid : tcp_in_valid;
  assign tx_src_b = (ser_ff == SER_PASS) ? fib_ser_in_byte :
                    (ser_ff == SER_CTRL) ? cpu_out_byte : tcp_in_byte;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_ff <= SER_PASS;
      baud_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      if (ser_idle) ser_ff <= to_ser(ctrl_ff[CTRL_SER_LSB +: 2]);
      tick_ff <= (baud_cnt_ff >= REG_W'(baud_ff - 16'h0001));
      baud_cnt_ff <= (baud_cnt_ff >= REG_W'(baud_ff - 16'h0001)) ? '0 :
                     REG_W'(baud_cnt_ff + 16'h0001);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stx_v_ff <= 1'b0;
      stx_b_ff <= '0;
      fso_v_ff <= 1'b0;
      fso_b_ff <= '0;
      cpu_v_ff <= 1'b0;
      cpu_u_ff <= 1'b0;
      cpu_b_ff <= '0;
      tco_v_ff <= 1'b0;
      tco_b_ff <= '0;
    end else begin
      stx_v_ff <= tx_src_v;
      stx_b_ff <= tx_src_b;
      fso_v_ff <= (ser_ff == SER_PASS) && ser_rx_valid;
      fso_b_ff <= ser_rx_byte;
      // USB only ever reaches the processor, never the fiber
      cpu_v_ff <= ctl_hit || usb_valid;
      // Source flag only rises with a real USB byte, so an idle cycle reads as zero
      cpu_u_ff <= !ctl_hit && usb_valid;
      cpu_b_ff <= ctl_hit ? ser_rx_byte : usb_byte;
      tco_v_ff <= (ser_ff == SER_BRIDGE) && ser_rx_valid;
      tco_b_ff <= ser_rx_byte;
    end
  end

  assign ser_tx_valid = stx_v_ff;
  assign ser_tx_byte = stx_b_ff;
  assign fib_ser_out_valid = fso_v_ff;
  assign fib_ser_out_byte = fso_b_ff;
  assign cpu_in_valid = cpu_v_ff;
  assign cpu_in_from_usb = cpu_u_ff;
  assign cpu_in_byte = cpu_b_ff;
  assign tcp_out_valid = tco_v_ff;
  assign tcp_out_byte = tco_b_ff;
  assign baud_tick = tick_ff;

  assign stat_w = {7'h00, rate_high, busy_ff, ser_ff, conv_ff, act, sel_ff};
  assign rd_mux = (reg_addr == REG_CTRL) ? ctrl_ff :
                  (reg_addr == REG_PRIO) ? prio_ff :
                  (reg_addr == REG_HALF) ? half_ff :
                  (reg_addr == REG_BAUD) ? baud_ff :
                  (reg_addr == REG_TCP) ? tcp_ff :
                  (reg_addr == REG_STAT) ? stat_w : '0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_tx_single_src: assert property (
    loc_valid |-> $past(in_valid[sel_ff]) && loc_data == $past(sel_ff ? in1_data : in0_data))
    else $error("tx output not from selected input");
  a_tx_copy_same: assert property (
    in_valid[0] && !sel_ff && !wait_ff |=> fib_valid && fib_data == $past(in0_data))
    else $error("fiber copy differs from input");
  a_raw_copy: assert property (
    rx_valid |=> raw_valid && raw_data == $past(rx_data))
    else $error("raw output altered");
  a_trans_pass: assert property (
    rx_valid && !rate_high && eff_conv == CONV_TRANS |=>
      first_converted_output_data == $past(rx_data) && second_converted_output_valid)
    else $error("transparent mode altered stream");
  a_rate_blank: assert property (
    rate_high |=> !second_converted_output_valid)
    else $error("second output not blanked");
  a_split_halves: assert property (
    rx_valid && eff_conv == CONV_SPLIT |=>
      first_converted_output_valid != second_converted_output_valid || $past(rate_high))
    else $error("split halves overlap");
  a_deep_trans: assert property (
    frame_start && deep |=> conv_ff == CONV_TRANS)
    else $error("conversion allowed with deep colour");
  a_prio_pick: assert property (
    sel_mode == SEL_PRIO && act == 2'h3 && can_switch && prio0 <= prio1 |=> !sel_ff)
    else $error("priority pick wrong");
  a_hold_idle: assert property (
    sel_mode != SEL_MANUAL && act == 2'h0 |=> $stable(sel_ff))
    else $error("selector moved with no input");
  a_bridge_local: assert property (
    ser_ff == SER_BRIDGE && ser_rx_valid |=> !fib_ser_out_valid ##0 tcp_out_valid)
    else $error("bridged byte leaked to fiber");

endmodule

// *** inc/avr_pkg.sv ***
// Package for the extender routing control block: register map, field
// positions, reset values, mode enumerations and timing constants.
// Assumes a single 250 MHz clock and word-addressed registers.
package avr_pkg;

  localparam int ADDR_W = 3;
  localparam int REG_W = 16;

  localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_PRIO = 3'h1;
  localparam logic [ADDR_W-1:0] REG_HALF = 3'h2;
  localparam logic [ADDR_W-1:0] REG_BAUD = 3'h3;
  localparam logic [ADDR_W-1:0] REG_TCP = 3'h4;
  localparam logic [ADDR_W-1:0] REG_STAT = 3'h5;

  localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [REG_W-1:0] PRIO_RST = 16'h0010;
  localparam logic [REG_W-1:0] HALF_RST = 16'h0780;
  localparam logic [REG_W-1:0] TCP_PORT_RST = 16'h1F41;

  localparam int CTRL_SELM_LSB = 0;
  localparam int CTRL_MAN_BIT = 2;
  localparam int CTRL_CONV_LSB = 3;
  localparam int CTRL_SER_LSB = 5;
  localparam int PRIO_W = 4;
  localparam int PRIO1_LSB = 4;

  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_RST = 57_600;
  localparam int BAUD_DIV_RST = CLK_HZ / BAUD_RST;

  typedef enum logic [1:0] {SEL_MANUAL, SEL_FIRST, SEL_PRIO, SEL_LAST} avr_sel_e;
  typedef enum logic [1:0] {CONV_TRANS, CONV_SPLIT, CONV_DOWN} avr_conv_e;
  typedef enum logic [1:0] {SER_PASS, SER_CTRL, SER_BRIDGE} avr_ser_e;

endpackage

// *** dv/avr_fiber_peer.sv ***
// Far unit model: sends one frame of W by H pixels on the fiber stream.
// Assumes start is pulsed only while the model is idle.
`timescale 1ns/1ps
module avr_fiber_peer #(
  parameter int W = 4,
  parameter int H = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic busy,
  output logic valid,
  output logic sof,
  output logic eol,
  output logic eof,
  output logic [23:0] data
);
  logic busy_ff;
  logic [7:0] col_ff, line_ff;
  logic [23:0] last_ff, pix;
  assign pix = {line_ff, col_ff, 8'hC6};
  assign busy = busy_ff;
  assign valid = busy_ff;
  assign sof = busy_ff && col_ff == 8'h00 && line_ff == 8'h00;
  assign eol = busy_ff && col_ff == 8'(W - 1);
  assign eof = eol && line_ff == 8'(H - 1);
  // Junk between frames, so a stale pixel can never pass for a good one
  assign data = busy_ff ? pix : ~last_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {busy_ff, col_ff, line_ff, last_ff} <= '0;
    end else if (!busy_ff) begin
      busy_ff <= start;
      {col_ff, line_ff} <= '0;
    end else begin
      last_ff <= pix;
      col_ff <= eol ? 8'h00 : col_ff + 8'h01;
      line_ff <= line_ff + {7'h00, eol};
      busy_ff <= !eof;
    end
  end
endmodule

// *** dv/avr_routing_ctl_bench.sv ***
// Bench for the routing block: conversion rows, reset values, selection,
// serial routing and baud pacing.
// Assumes avr_fiber_peer drives the fiber stream; clk runs at 250 MHz.
`timescale 1ns/1ps
module avr_routing_ctl_bench
  import avr_pkg::*;
;
  typedef struct {avr_conv_e conv; logic rate; logic deep; int e1; int e2;} avr_row_s;
  avr_row_s rows [5] = '{
    '{CONV_TRANS, 1'b0, 1'b0, 8, 8},
    '{CONV_TRANS, 1'b1, 1'b0, 8, 0},
    '{CONV_SPLIT, 1'b0, 1'b0, 4, 4},
    '{CONV_SPLIT, 1'b0, 1'b1, 8, 8},
    '{CONV_DOWN, 1'b0, 1'b0, 8, 8}
  };
  logic [18:0] regs [6] = '{{REG_CTRL, CTRL_RST}, {REG_PRIO, PRIO_RST}, {REG_HALF, HALF_RST},
    {REG_TCP, TCP_PORT_RST}, {3'h6, 16'h0000}, {3'h7, 16'h0000}};
  localparam int DIV = 8;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, tr = 1'b0;
  logic rate_high_pin = 1'b0, deep_color_pin = 1'b0;
  logic dn = 1'b0, ser_idle = 1'b1, cpu_out_valid = 1'b0;
  logic [7:0] cpu_out_byte = '0;
  logic [8:0] tx_exp [3] = '{9'h1A5, 9'h196, 9'h000};
  logic ser_rx_valid = 1'b0, fib_ser_in_valid = 1'b0, usb_valid = 1'b0, tcp_in_valid = 1'b0;
  logic [2:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, tcp_port;
  logic [1:0] in_active_pin = '0, in_valid = '0, in_sof = '0, in_eol = '0, in_eof = '0;
  logic [23:0] in0_data = '0, in1_data = '0, rx_data, loc_data, fib_data, raw_data;
  logic [23:0] c1_data, c2_data;
  logic [7:0] ser_rx_byte = '0, fib_ser_in_byte = '0, usb_byte = '0, tcp_in_byte = '0;
  logic [7:0] ser_tx_byte, fib_ser_out_byte, cpu_in_byte, tcp_out_byte;
  logic rx_valid, rx_sof, rx_eol, rx_eof, raw_valid, raw_sof, raw_eol, raw_eof, busy;
  logic loc_valid, loc_sof, fib_valid, fib_sof, c1_valid, c2_valid, ser_tx_valid, baud_tick;
  logic fib_ser_out_valid, cpu_in_valid, cpu_in_from_usb, tcp_out_valid;
  logic [27:0] prev;
  int error_cnt = 0, checked = 0, n1 = 0, n2 = 0;

  avr_routing_ctl #(.VID_W(24), .BAUD_DIV(16'h0008)) u_avr_routing_ctl (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_active_pin,
    .rate_high_pin, .deep_color_pin, .in_valid, .in_sof, .in_eol, .in_eof, .in0_data, .in1_data,
    .loc_valid, .loc_sof, .loc_eol(), .loc_eof(), .loc_data, .fib_valid, .fib_sof, .fib_eol(),
    .fib_eof(), .fib_data, .rx_valid, .rx_sof, .rx_eol, .rx_eof, .rx_data, .raw_valid, .raw_sof,
    .raw_eol, .raw_eof, .raw_data, .first_converted_output_valid(c1_valid),
    .first_converted_output_sof(), .first_converted_output_eol(),
    .first_converted_output_data(c1_data), .second_converted_output_valid(c2_valid),
    .second_converted_output_sof(), .second_converted_output_eol(),
    .second_converted_output_data(c2_data), .ser_idle, .ser_rx_valid, .ser_rx_byte,
    .ser_tx_valid, .ser_tx_byte, .baud_tick, .fib_ser_in_valid, .fib_ser_in_byte,
    .fib_ser_out_valid, .fib_ser_out_byte, .cpu_in_valid, .cpu_in_from_usb, .cpu_in_byte,
    .cpu_out_valid, .cpu_out_byte, .usb_valid, .usb_byte, .usb_ready(),
    .tcp_in_valid, .tcp_in_byte, .tcp_out_valid, .tcp_out_byte, .tcp_port);

  avr_fiber_peer #(.W(4), .H(2)) u_avr_fiber_peer (.clk, .reset_n, .start(go), .busy,
    .valid(rx_valid), .sof(rx_sof), .eol(rx_eol), .eof(rx_eof), .data(rx_data));

  always #2 clk = ~clk;

  task automatic close_out();
    $display("checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic sel_is(input logic e);
    logic [15:0] v;
    repeat (8) @(posedge clk);
    rd(REG_STAT, v);
    chk(v[0], e);
  endtask

  task automatic wait_frame();
    int k;
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 100) begin
      error_cnt++;
      close_out();
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic tick_gap(output int n);
    n = 0;
    @(posedge clk);
    #1;
    while (baud_tick !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Quarter-chroma pixel: even line keeps Cb on even and Cr on odd columns, odd line luma only
  function automatic logic [23:0] dn_px(input logic [23:0] p);
    dn_px = {p[23:16], (p[16] | p[8]) ? 8'h00 : p[15:8], (p[16] | !p[8]) ? 8'h00 : p[7:0]};
  endfunction

  always @(posedge clk) prev <= {rx_valid, rx_sof, rx_eol, rx_eof, rx_data};

  always @(negedge clk) begin
    if (prev[27] === 1'b1 || raw_valid === 1'b1)
      chk({raw_valid, raw_sof, raw_eol, raw_eof, raw_data}, prev);
    if (dn && c1_valid === 1'b1) chk(c1_data, dn_px(raw_data));
    if (dn && c2_valid === 1'b1) chk(c2_data, dn_px(raw_data));
    if (tr && c1_valid === 1'b1) chk(c1_data, raw_data);
    if (tr && c2_valid === 1'b1) chk(c2_data, raw_data);
    if (c1_valid === 1'b1) n1++;
    if (c2_valid === 1'b1) n2++;
  end

  initial begin
    logic [15:0] v;
    int n;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wr(REG_HALF, 16'h0002);
    for (int i = 0; i < 5; i++) begin
      {rate_high_pin, deep_color_pin} <= {rows[i].rate, rows[i].deep};
      wr(REG_CTRL, {11'h000, rows[i].conv, 3'h0});
      repeat (8) @(posedge clk);
      n1 = 0;
      n2 = 0;
      tr = rows[i].conv == CONV_TRANS || rows[i].deep;
      dn = rows[i].conv == CONV_DOWN && !rows[i].deep;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_frame();
      chk(n1, rows[i].e1);
      chk(n2, rows[i].e2);
    end
    // Second reset in mid-run must bring back the CTRL, PRIO, HALF and TCP reset values
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wr(3'h6, 16'hFFFF);
    foreach (regs[i]) begin
      rd(regs[i][18:16], v);
      chk(v, regs[i][15:0]);
    end
    chk(tcp_port, TCP_PORT_RST);
    wr(REG_CTRL, 16'h0004);
    repeat (8) @(posedge clk);
    {in_valid, in_sof, in_eol, in_eof} <= 8'hFF;
    {in0_data, in1_data} <= {24'h11_1111, 24'h22_2222};
    @(posedge clk);
    {in_valid, in_sof, in_eol, in_eof} <= 8'h00;
    #1;
    chk({loc_valid, loc_sof, loc_data}, {2'b11, 24'h22_2222});
    chk({fib_valid, fib_sof, fib_data}, {2'b11, 24'h22_2222});
    wr(REG_CTRL, 16'h0000);
    repeat (8) @(posedge clk);
    {in_valid, in_sof, in0_data} <= {4'h5, 24'h33_3333};
    @(posedge clk);
    {in_sof, in0_data} <= {2'b00, 24'h44_4444};
    @(posedge clk);
    in_valid <= 2'b00;
    #1;
    chk({loc_valid, loc_sof, loc_data}, {2'b10, 24'h44_4444});
    chk({fib_valid, fib_sof, fib_data}, {2'b10, 24'h44_4444});
    in_active_pin <= 2'b11;
    wr(REG_CTRL, 16'h0002);
    wr(REG_PRIO, 16'h0010);
    sel_is(1'b0);
    wr(REG_PRIO, 16'h0001);
    sel_is(1'b1);
    in_active_pin <= 2'b00;
    sel_is(1'b1);
    wr(REG_CTRL, 16'h0003);
    in_active_pin <= 2'b01;
    sel_is(1'b0);
    in_active_pin <= 2'b11;
    sel_is(1'b1);
    wr(REG_CTRL, 16'h0001);
    in_active_pin <= 2'b01;
    sel_is(1'b0);
    in_active_pin <= 2'b11;
    sel_is(1'b0);
    for (int m = 0; m < 3; m++) begin
      wr(REG_CTRL, 16'(m << 5));
      repeat (2) @(posedge clk);
      {ser_rx_valid, fib_ser_in_valid, cpu_out_valid} <= 3'b111;
      {ser_rx_byte, fib_ser_in_byte, cpu_out_byte} <= 24'h5A_A596;
      @(posedge clk);
      {ser_rx_valid, fib_ser_in_valid, cpu_out_valid} <= 3'b000;
      #1;
      chk({fib_ser_out_valid, cpu_in_valid, tcp_out_valid, cpu_in_from_usb}, 8 >> m);
      chk(m == 0 ? fib_ser_out_byte : m == 1 ? cpu_in_byte : tcp_out_byte, 8'h5A);
      chk({ser_tx_valid, ser_tx_byte & {8{ser_tx_valid}}}, tx_exp[m]);
    end
    @(posedge clk);
    {tcp_in_valid, usb_valid, tcp_in_byte, usb_byte} <= {2'b11, 16'hC33C};
    @(posedge clk);
    {tcp_in_valid, usb_valid} <= 2'b00;
    #1;
    chk({ser_tx_valid, cpu_in_valid, cpu_in_from_usb, fib_ser_out_valid}, 4'hE);
    chk({ser_tx_byte, cpu_in_byte}, 16'hC33C);
    // A character in flight pins the serial mode until the line goes idle
    @(posedge clk);
    ser_idle <= 1'b0;
    wr(REG_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    ser_rx_valid <= 1'b1;
    @(posedge clk);
    ser_rx_valid <= 1'b0;
    #1;
    chk({fib_ser_out_valid, tcp_out_valid}, 2'b01);
    @(posedge clk);
    ser_idle <= 1'b1;
    repeat (2) @(posedge clk);
    ser_rx_valid <= 1'b1;
    @(posedge clk);
    ser_rx_valid <= 1'b0;
    #1;
    chk({fib_ser_out_valid, tcp_out_valid}, 2'b10);
    tick_gap(n);
    tick_gap(n);
    chk(n, DIV - 1);
    close_out();
  end
endmodule
